// ### rtl/rudp_defs.svh
`ifndef RUDP_DEFS_SVH
`define RUDP_DEFS_SVH

// register indices on the local register port (word addresses)
`define RUDP_ADDR_W            4
`define RUDP_IDX_USER_BASE     4'h0
`define RUDP_IDX_KERN_PBASE    4'h1
`define RUDP_IDX_RAM_SIZE      4'h2
`define RUDP_IDX_STATUS        4'h3

// field layout of the user data base register
`define RUDP_BASE_MSB          15
`define RUDP_BASE_LSB          10
`define RUDP_BASE_W            6
`define RUDP_USER_BASE_RST     6'h00

// ram addressing: byte offset inside data ram
`define RUDP_RAM_AW            16

// status register bit positions
`define RUDP_ST_USER_EN        0
`define RUDP_ST_BAD_KERN       1
`define RUDP_ST_BAD_SIZE       2

`endif

// ### rtl/rudp_pkg.sv
package rudp_pkg;
   `include "rudp_defs.svh"

   typedef struct packed {
      logic                      wr;
      logic                      rd;
      logic [`RUDP_ADDR_W-1:0]   addr;
      logic [31:0]               wdata;
   } rudp_bus_t;

   typedef struct packed {
      logic                      valid;
      logic                      user_mode;
      logic [`RUDP_RAM_AW-1:0]   addr;
   } rudp_acc_t;

   typedef enum logic [1:0] {
      RUDP_KERNEL_ONLY = 2'b00,
      RUDP_SPLIT       = 2'b01
   } rudp_mode_t;
endpackage

// ### rtl/rudp_partition.sv
`timescale 1ns/1ps
`include "rudp_defs.svh"
module rudp_partition
   import rudp_pkg::*;
(
   input  wire logic                    core_clk_i,
   input  wire logic                    sys_rst_i,
   input  wire rudp_bus_t               bus_i,
   output logic [31:0]                  rdata_o,
   input  wire rudp_acc_t               acc_i,
   output logic                         acc_grant_o,
   output logic                         acc_user_region_o,
   output logic                         acc_viol_o,
   output logic [`RUDP_BASE_W-1:0]      user_base_o
);

   logic [`RUDP_BASE_W-1:0]   base_r;
   logic [`RUDP_BASE_W-1:0]   base_nxt;
   logic [`RUDP_BASE_W-1:0]   kpb_r;
   logic [`RUDP_BASE_W-1:0]   kpb_nxt;
   logic [`RUDP_BASE_W-1:0]   size_r;
   logic [`RUDP_BASE_W-1:0]   size_nxt;
   logic [31:0]               rdata_r;
   logic [31:0]               rdata_nxt;
   logic                      grant_r;
   logic                      grant_nxt;
   logic                      region_r;
   logic                      region_nxt;
   logic                      viol_r;
   logic                      viol_nxt;
   rudp_mode_t                mode;
   logic [`RUDP_RAM_AW-1:0]   base_bytes;
   logic                      in_user;
   logic                      bad_kern;
   logic                      bad_size;

   // companion limits are held here so software can read back the checks
   always_comb
   begin
      base_nxt = base_r;
      kpb_nxt  = kpb_r;
      size_nxt = size_r;
      if (bus_i.wr)
      begin
         case (bus_i.addr)
            `RUDP_IDX_USER_BASE:  base_nxt = bus_i.wdata[`RUDP_BASE_MSB:`RUDP_BASE_LSB];
            `RUDP_IDX_KERN_PBASE: kpb_nxt  = bus_i.wdata[`RUDP_BASE_MSB:`RUDP_BASE_LSB];
            `RUDP_IDX_RAM_SIZE:   size_nxt = bus_i.wdata[`RUDP_BASE_MSB:`RUDP_BASE_LSB];
            default:              base_nxt = base_r;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         base_r <= `RUDP_USER_BASE_RST;
         kpb_r  <= '0;
         size_r <= '0;
      end
      else
      begin
         base_r <= base_nxt;
         kpb_r  <= kpb_nxt;
         size_r <= size_nxt;
      end
   end

   // bad settings are only flagged, never corrected: keeping them legal is software's job
   assign bad_kern = (base_r != '0) && (base_r <= kpb_r);
   assign bad_size = (base_r > size_r);

   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            `RUDP_IDX_USER_BASE:  rdata_nxt[`RUDP_BASE_MSB:`RUDP_BASE_LSB] = base_r;
            `RUDP_IDX_KERN_PBASE: rdata_nxt[`RUDP_BASE_MSB:`RUDP_BASE_LSB] = kpb_r;
            `RUDP_IDX_RAM_SIZE:   rdata_nxt[`RUDP_BASE_MSB:`RUDP_BASE_LSB] = size_r;
            `RUDP_IDX_STATUS:
            begin
               rdata_nxt[`RUDP_ST_USER_EN]  = (base_r != '0);
               rdata_nxt[`RUDP_ST_BAD_KERN] = bad_kern;
               rdata_nxt[`RUDP_ST_BAD_SIZE] = bad_size;
            end
            default:              rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   assign mode       = (base_r == '0) ? RUDP_KERNEL_ONLY : RUDP_SPLIT;
   assign base_bytes = {base_r, 10'h000};
   assign in_user    = (mode == RUDP_SPLIT) && (acc_i.addr >= base_bytes);

   always_comb
   begin
      grant_nxt  = 1'b0;
      region_nxt = 1'b0;
      viol_nxt   = 1'b0;
      if (acc_i.valid)
      begin
         case (mode)
            RUDP_KERNEL_ONLY:
            begin
               // user mode has no data ram at all while the base is zero
               grant_nxt = !acc_i.user_mode;
               viol_nxt  = acc_i.user_mode;
            end
            RUDP_SPLIT:
            begin
               region_nxt = in_user;
               grant_nxt  = in_user || !acc_i.user_mode;
               viol_nxt   = acc_i.user_mode && !in_user;
            end
            default:
            begin
               grant_nxt = 1'b0;
               viol_nxt  = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         rdata_r  <= 32'h0000_0000;
         grant_r  <= 1'b0;
         region_r <= 1'b0;
         viol_r   <= 1'b0;
      end
      else
      begin
         rdata_r  <= rdata_nxt;
         grant_r  <= grant_nxt;
         region_r <= region_nxt;
         viol_r   <= viol_nxt;
      end
   end

   assign rdata_o           = rdata_r;
   assign acc_grant_o       = grant_r;
   assign acc_user_region_o = region_r;
   assign acc_viol_o        = viol_r;
   assign user_base_o       = base_r;

   a_upper_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) |-> rdata_o[31:16] == 16'h0000)
      else $error("upper bits not zero");

   a_low_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && ($past(bus_i.addr) == `RUDP_IDX_USER_BASE) |-> rdata_o[9:0] == 10'h000)
      else $error("low bits not zero");

   a_base_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      bus_i.wr && bus_i.addr == `RUDP_IDX_USER_BASE |=> user_base_o == $past(bus_i.wdata[15:10]))
      else $error("base not written");

   a_base_readback: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      bus_i.rd && bus_i.addr == `RUDP_IDX_USER_BASE && !bus_i.wr |=> rdata_o[15:10] == $past(base_r))
      else $error("base readback wrong");

   a_reset_clear: assert property (@(posedge core_clk_i)
      sys_rst_i |=> user_base_o == 6'h00 && rdata_o == 32'h0000_0000)
      else $error("reset did not clear");

   a_kernel_only: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_i.valid && base_r == '0 |=> !acc_user_region_o && (acc_grant_o != acc_viol_o))
      else $error("zero base gave user region");

   a_user_region: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_i.valid && acc_i.user_mode && base_r != '0 && acc_i.addr >= {base_r, 10'h000} |=> acc_grant_o)
      else $error("user access refused");

   a_user_below: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_i.valid && acc_i.user_mode && acc_i.addr < {base_r, 10'h000} |=> acc_viol_o && !acc_grant_o)
      else $error("user below base granted");

   a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !acc_i.valid |=> !acc_grant_o && !acc_viol_o && !acc_user_region_o)
      else $error("answer without access");

   a_read_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !$past(bus_i.rd)
      |-> rdata_o == 32'h0000_0000)
      else $error("read data outside read cycle");

   a_base_read_full: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_USER_BASE
      |-> rdata_o == {16'h0000, $past(base_r), 10'h000})
      else $error("base read word wrong");

   a_kpb_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      bus_i.wr && bus_i.addr == `RUDP_IDX_KERN_PBASE
      |=> kpb_r == $past(bus_i.wdata[`RUDP_BASE_MSB:`RUDP_BASE_LSB]))
      else $error("kernel base not written");

   a_size_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      bus_i.wr && bus_i.addr == `RUDP_IDX_RAM_SIZE
      |=> size_r == $past(bus_i.wdata[`RUDP_BASE_MSB:`RUDP_BASE_LSB]))
      else $error("ram size not written");

   a_kpb_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_KERN_PBASE
      |-> rdata_o == {16'h0000, $past(kpb_r), 10'h000})
      else $error("kernel base readback wrong");

   a_size_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_RAM_SIZE
      |-> rdata_o == {16'h0000, $past(size_r), 10'h000})
      else $error("ram size readback wrong");

   a_status_user: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_STATUS
      |-> rdata_o[`RUDP_ST_USER_EN] == ($past(base_r) != 6'h00))
      else $error("status user bit wrong");

   a_status_kern: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_STATUS
      |-> rdata_o[`RUDP_ST_BAD_KERN] == ($past(base_r) != 6'h00 && $past(base_r) <= $past(kpb_r)))
      else $error("status kernel bit wrong");

   a_status_size: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_STATUS
      |-> rdata_o[`RUDP_ST_BAD_SIZE] == ($past(base_r) > $past(size_r)))
      else $error("status size bit wrong");

   a_status_upper: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) == `RUDP_IDX_STATUS
      |-> rdata_o[31:`RUDP_ST_BAD_SIZE+1] == 29'h0000_0000)
      else $error("status spare bits not zero");

   a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $past(bus_i.rd) && $past(bus_i.addr) > `RUDP_IDX_STATUS
      |-> rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   // the reset term keeps the clearing edge itself out of the hold checks
   a_base_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && !(bus_i.wr && bus_i.addr == `RUDP_IDX_USER_BASE)
      |=> $stable(user_base_o))
      else $error("base changed without write");

   a_kpb_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && !(bus_i.wr && bus_i.addr == `RUDP_IDX_KERN_PBASE)
      |=> $stable(kpb_r))
      else $error("kernel base changed without write");

   a_size_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && !(bus_i.wr && bus_i.addr == `RUDP_IDX_RAM_SIZE)
      |=> $stable(size_r))
      else $error("ram size changed without write");

   a_grant_excl: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_grant_o
      |-> !acc_viol_o)
      else $error("grant and violation together");

   a_region_granted: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_user_region_o
      |-> acc_grant_o)
      else $error("user region access not granted");

   a_kernel_grant: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_i.valid && !acc_i.user_mode
      |=> acc_grant_o && !acc_viol_o)
      else $error("kernel access refused");

   a_kernel_region: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_i.valid && !acc_i.user_mode && base_r != 6'h00 && acc_i.addr >= {base_r, 10'h000}
      |=> acc_user_region_o)
      else $error("kernel access in user region not flagged");

   a_viol_user: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_viol_o
      |-> $past(acc_i.valid) && $past(acc_i.user_mode))
      else $error("violation without user access");

   a_region_base: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_user_region_o
      |-> $past(base_r) != 6'h00)
      else $error("user region with zero base");

   a_below_no_region: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_i.valid && acc_i.addr < {base_r, 10'h000}
      |=> !acc_user_region_o)
      else $error("region flagged below base");

   c_split_set: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      base_r == '0 ##1 base_r != '0);
   c_user_grant: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_user_region_o && acc_grant_o);
   c_user_viol: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_viol_o);
   c_bad_kern: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      bad_kern);
   c_kernel_user: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
      acc_user_region_o && !$past(acc_i.user_mode));
endmodule

// ### sim/rudp_partition_tb_top.sv
`timescale 1ns/1ps
`include "rudp_defs.svh"
module rudp_partition_tb_top
   import rudp_pkg::*;
();
   logic         core_clk_i;
   logic         sys_rst_i;
   rudp_bus_t    bus;
   rudp_acc_t    acc;
   logic [31:0]  rdata;
   logic         grant;
   logic         region;
   logic         viol;
   logic [5:0]   ubase;
   int           err_total;
   int           n_tests;

   rudp_partition rudp_partition_i (
      .core_clk_i        (core_clk_i),
      .sys_rst_i         (sys_rst_i),
      .bus_i             (bus),
      .rdata_o           (rdata),
      .acc_i             (acc),
      .acc_grant_o       (grant),
      .acc_user_region_o (region),
      .acc_viol_o        (viol),
      .user_base_o       (ubase)
   );

   initial core_clk_i = 1'b0;
   always #10 core_clk_i = ~core_clk_i;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_i);
      bus <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
   endtask

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge core_clk_i);
      bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   // e is {grant, region, viol}
   task automatic ac(input logic u, input logic [15:0] a, input logic [2:0] e);
      @(posedge core_clk_i);
      acc <= '{valid: 1'b1, user_mode: u, addr: a};
      @(posedge core_clk_i);
      acc.valid <= 1'b0;
      #1 chk({29'h0, grant, region, viol}, {29'h0, e});
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge core_clk_i);
      err_total++;
      report_and_stop();
   end

   initial
   begin
      err_total = 0;
      n_tests   = 0;
      sys_rst_i = 1'b1;
      bus       = '0;
      acc       = '0;
      repeat (20) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(`RUDP_IDX_USER_BASE, 32'h0);
      chk({26'h0, ubase}, 32'h0);
      ac(1'b1, 16'h0000, 3'b001);
      ac(1'b0, 16'h7fff, 3'b100);
      wr(`RUDP_IDX_USER_BASE, 32'hffff_ffff);
      rd(`RUDP_IDX_USER_BASE, 32'h0000_fc00);
      ac(1'b1, 16'hfbff, 3'b001);
      ac(1'b1, 16'hfc00, 3'b110);
      wr(`RUDP_IDX_USER_BASE, 32'h1234_1fff);
      rd(`RUDP_IDX_USER_BASE, 32'h0000_1c00);
      chk({26'h0, ubase}, 32'h7);
      ac(1'b1, 16'h1bff, 3'b001);
      ac(1'b1, 16'h1c00, 3'b110);
      ac(1'b0, 16'h0400, 3'b100);
      ac(1'b0, 16'h2000, 3'b110);
      rd(4'h4, 32'h0);
      // device only flags bad software settings, it does not clamp them
      wr(`RUDP_IDX_KERN_PBASE, 32'h0000_2000);
      wr(`RUDP_IDX_RAM_SIZE, 32'h0000_1800);
      rd(`RUDP_IDX_STATUS, 32'h7);
      wr(`RUDP_IDX_KERN_PBASE, 32'h0000_1000);
      wr(`RUDP_IDX_RAM_SIZE, 32'h0000_8000);
      rd(`RUDP_IDX_STATUS, 32'h1);
      rd(`RUDP_IDX_USER_BASE, 32'h0000_1c00);
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(`RUDP_IDX_USER_BASE, 32'h0);
      ac(1'b1, 16'h2000, 3'b001);
      ac(1'b0, 16'h2000, 3'b100);
      report_and_stop();
   end
endmodule
